// file: core/fcpc_pkg.sv
// Package for the fast clock and power configuration block
package fcpc_pkg;

  localparam int unsigned FCPC_CLK_MHZ = 125;

  // Register byte offsets
  localparam logic [7:0] FCPC_OFS_CFG = 8'h00;
  localparam logic [7:0] FCPC_OFS_STAT = 8'h04;

  // Reset value of the configuration word
  localparam logic [31:0] FCPC_CFG_RST = 32'h0000_0138;

  // Status word bit positions
  localparam int unsigned FCPC_ST_READY = 0;
  localparam int unsigned FCPC_ST_ON = 1;
  localparam int unsigned FCPC_ST_F8M = 2;
  localparam int unsigned FCPC_ST_ERR = 3;

  // Settling times in microseconds, index = settle code
  localparam int unsigned FCPC_SETTLE_US [8] =
    '{74, 104, 135, 196, 257, 379, 502, 5000};
  // High baud oscillator timeouts in milliseconds, index = timeout code
  localparam int unsigned FCPC_FAST_BAUD_OSC_TIMEOUT_MS [8] =
    '{10, 20, 30, 40, 60, 80, 100, 120};
  // Supply check divisors, index = rate code (0 means off)
  localparam logic [6:0] FCPC_SUPPLY_DIV [8] =
    '{7'h00, 7'h01, 7'h02, 7'h05, 7'h0a, 7'h14, 7'h32, 7'h64};

  localparam logic [2:0] FCPC_RATE_OFF = 3'h0;

  typedef struct packed {
    logic [15:0] upper;
    logic [2:0] supply_check_rate;
    logic housekeeping_clock_mode;
    logic [2:0] fast_osc_cal_rate;
    logic fast_osc_freq_select;
    logic [2:0] fast_baud_osc_timeout;
    logic [2:0] fast_osc_settle_time;
    logic [1:0] must_zero;
  } fcpc_cfg_t;

  // Packed from bit 3 down, so osc_ready lands on bit 0
  typedef struct packed {
    logic cfg_err;
    logic freq_8m;
    logic osc_on;
    logic osc_ready;
  } fcpc_stat_t;

  typedef enum logic [1:0] {FCPC_OFF, FCPC_SETTLE, FCPC_ON} fcpc_osc_t;

endpackage

// file: core/fcpc_core.sv
// Fast clock and power configuration: APB register, rate counters, osc
//
// Contract
// - The supply check rate field at bits 15:13 resets to 0; 0 is off and 1 checks on every trigger.
// - Supply check codes 2 to 7 check on every 2nd, 5th, 10th, 20th, 50th and 100th trigger via a counter.
// - Bit 12 chooses whether housekeeping runs without (0, reset) or with (1) the fast oscillator started first.
// - The calibration rate field at bits 11:9 resets to 0; 0 is off and 1 calibrates on every trigger.
// - Bit 8 selects a nominal 4 MHz (0) or 8 MHz (1) fast oscillator and resets to 1.
// - Bit 8 applies only in flow meter mode; otherwise the shadow register selector is used.
// - With high baud enabled the oscillator is held on for the timeout chosen by bits 7:5, reset 001.
// - After an oscillator request the settling time chosen by bits 4:2 (reset 110) passes before use.
`timescale 1ns/1ps
module fcpc_core
  import fcpc_pkg::*;
#(
  parameter logic [23:0] SETTLE_CYC [8] = '{
    24'(FCPC_SETTLE_US[0] * FCPC_CLK_MHZ),
    24'(FCPC_SETTLE_US[1] * FCPC_CLK_MHZ),
    24'(FCPC_SETTLE_US[2] * FCPC_CLK_MHZ),
    24'(FCPC_SETTLE_US[3] * FCPC_CLK_MHZ),
    24'(FCPC_SETTLE_US[4] * FCPC_CLK_MHZ),
    24'(FCPC_SETTLE_US[5] * FCPC_CLK_MHZ),
    24'(FCPC_SETTLE_US[6] * FCPC_CLK_MHZ),
    24'(FCPC_SETTLE_US[7] * FCPC_CLK_MHZ)},
  parameter logic [23:0] FAST_BAUD_OSC_TIMEOUT_CYC [8] = '{
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[0] * FCPC_CLK_MHZ * 1000),
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[1] * FCPC_CLK_MHZ * 1000),
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[2] * FCPC_CLK_MHZ * 1000),
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[3] * FCPC_CLK_MHZ * 1000),
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[4] * FCPC_CLK_MHZ * 1000),
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[5] * FCPC_CLK_MHZ * 1000),
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[6] * FCPC_CLK_MHZ * 1000),
    24'(FCPC_FAST_BAUD_OSC_TIMEOUT_MS[7] * FCPC_CLK_MHZ * 1000)},
  parameter logic [6:0] CAL_DIV [8] =
    '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40}
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_trig,
  input wire logic flow_mode,
  input wire logic shadow_freq_sel,
  input wire logic osc_req,
  input wire logic gph_req,
  input wire logic hbr_en,
  input wire logic hbr_activity,
  output logic supply_check_req,
  output logic osc_cal_req,
  output logic fast_osc_freq_8m,
  output logic osc_on,
  output logic osc_ready
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] cal_div(input logic [2:0] code);
    cal_div = CAL_DIV[code];
  endfunction

  // True when a counter has reached its divisor minus one, so this trigger must fire
  function automatic logic div_hit(input logic [6:0] cnt,
                                   input logic [6:0] div);
    div_hit = (div != 7'h00) && (cnt >= div - 7'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state on every access
  fcpc_cfg_t cfg_r, cfg_nxt;
  logic cfg_err_r, cfg_err_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  fcpc_stat_t stat;
  logic hit_cfg, hit_stat, access_end;
  fcpc_osc_t osc_st_r, osc_st_nxt;
  logic freq_8m_r, freq_8m_nxt;

  assign stat = '{osc_ready: (osc_st_r == FCPC_ON),
                  osc_on: (osc_st_r != FCPC_OFF),
                  freq_8m: freq_8m_r,
                  cfg_err: cfg_err_r};

  always_comb
  begin
    hit_cfg = (paddr == FCPC_OFS_CFG);
    hit_stat = (paddr == FCPC_OFS_STAT);
    access_end = psel && penable && pready_r;
    cfg_nxt = cfg_r;
    cfg_err_nxt = cfg_err_r;
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (pready_nxt)
    begin
      pslverr_nxt = !(hit_cfg || (hit_stat && !pwrite));
      prdata_nxt = 32'h0000_0000;
      if (!pwrite && hit_cfg)
        prdata_nxt = cfg_r;
      else if (!pwrite && hit_stat)
        prdata_nxt = {28'h000_0000, stat};
    end
    if (access_end && pwrite && hit_cfg)
    begin
      // Upper half belongs to other logic and reads as zero here
      cfg_nxt = pwdata;
      cfg_nxt.upper = 16'h0000;
      // Unsupported low bits are never stored, only flagged
      cfg_nxt.must_zero = 2'b00;
      cfg_err_nxt = (pwdata[1:0] != 2'b00);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= FCPC_CFG_RST;
      cfg_err_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      cfg_err_r <= cfg_err_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////
  // Trigger divider counters for supply check and calibration
  logic [6:0] sup_cnt_r, sup_cnt_nxt, cal_cnt_r, cal_cnt_nxt;
  logic sup_req_r, sup_req_nxt, cal_req_r, cal_req_nxt;
  logic [6:0] sup_div, cal_dv;

  always_comb
  begin
    sup_div = FCPC_SUPPLY_DIV[cfg_r.supply_check_rate];
    cal_dv = cal_div(cfg_r.fast_osc_cal_rate);
    sup_cnt_nxt = sup_cnt_r;
    cal_cnt_nxt = cal_cnt_r;
    sup_req_nxt = 1'b0;
    cal_req_nxt = 1'b0;
    // Off codes park the counters so a later enable starts clean
    if (cfg_r.supply_check_rate == FCPC_RATE_OFF)
      sup_cnt_nxt = 7'h00;
    else if (meas_trig && div_hit(sup_cnt_r, sup_div))
    begin
      sup_cnt_nxt = 7'h00;
      sup_req_nxt = 1'b1;
    end
    else if (meas_trig)
      sup_cnt_nxt = sup_cnt_r + 7'h01;
    if (cfg_r.fast_osc_cal_rate == FCPC_RATE_OFF)
      cal_cnt_nxt = 7'h00;
    else if (meas_trig && div_hit(cal_cnt_r, cal_dv))
    begin
      cal_cnt_nxt = 7'h00;
      cal_req_nxt = 1'b1;
    end
    else if (meas_trig)
      cal_cnt_nxt = cal_cnt_r + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sup_cnt_r <= 7'h00;
      cal_cnt_r <= 7'h00;
      sup_req_r <= 1'b0;
      cal_req_r <= 1'b0;
    end
    else
    begin
      sup_cnt_r <= sup_cnt_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      sup_req_r <= sup_req_nxt;
      cal_req_r <= cal_req_nxt;
    end
  end

  assign supply_check_req = sup_req_r;
  assign osc_cal_req = cal_req_r;

  ////////////////////////////////////////////////////////////////////////
  // Fast oscillator control: high baud hold, settling, frequency select
  logic [23:0] hold_cnt_r, hold_cnt_nxt, settle_cnt_r, settle_cnt_nxt;
  logic demand;
  logic osc_on_r, osc_on_nxt, osc_ready_r, osc_ready_nxt;

  always_comb
  begin
    hold_cnt_nxt = hold_cnt_r;
    if (!hbr_en)
      hold_cnt_nxt = 24'h00_0000;
    else if (hbr_activity)
      hold_cnt_nxt = FAST_BAUD_OSC_TIMEOUT_CYC[cfg_r.fast_baud_osc_timeout];
    else if (hold_cnt_r != 24'h00_0000)
      hold_cnt_nxt = hold_cnt_r - 24'h00_0001;
    // Calibration also needs the oscillator running
    demand = osc_req || cal_req_r || (hbr_en && hold_cnt_r != 24'h00_0000)
      || (gph_req && cfg_r.housekeeping_clock_mode);
    osc_st_nxt = osc_st_r;
    settle_cnt_nxt = settle_cnt_r;
    unique case (osc_st_r)
      FCPC_OFF:
        if (demand)
        begin
          osc_st_nxt = FCPC_SETTLE;
          settle_cnt_nxt =
            SETTLE_CYC[cfg_r.fast_osc_settle_time];
        end
      FCPC_SETTLE:
        if (!demand)
          osc_st_nxt = FCPC_OFF;
        else if (settle_cnt_r <= 24'h00_0001)
          osc_st_nxt = FCPC_ON;
        else
          settle_cnt_nxt = settle_cnt_r - 24'h00_0001;
      FCPC_ON:
        if (!demand)
          osc_st_nxt = FCPC_OFF;
      default:
        osc_st_nxt = FCPC_OFF;
    endcase
    // Registered copies keep the pins free of decode glitches
    osc_on_nxt = (osc_st_nxt != FCPC_OFF);
    osc_ready_nxt = (osc_st_nxt == FCPC_ON);
    // Shadow selector rules outside flow meter mode
    freq_8m_nxt = flow_mode ? cfg_r.fast_osc_freq_select
                            : shadow_freq_sel;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt_r <= 24'h00_0000;
      settle_cnt_r <= 24'h00_0000;
      osc_st_r <= FCPC_OFF;
      freq_8m_r <= 1'b1;
      osc_on_r <= 1'b0;
      osc_ready_r <= 1'b0;
    end
    else
    begin
      hold_cnt_r <= hold_cnt_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      osc_st_r <= osc_st_nxt;
      freq_8m_r <= freq_8m_nxt;
      osc_on_r <= osc_on_nxt;
      osc_ready_r <= osc_ready_nxt;
    end
  end

  assign fast_osc_freq_8m = freq_8m_r;
  assign osc_on = osc_on_r;
  assign osc_ready = osc_ready_r;

endmodule

// file: tb/fcpc_core_properties.sv
// Checker for the fast clock and power configuration block
`timescale 1ns/1ps
module fcpc_core_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic meas_trig,
  input wire logic flow_mode,
  input wire logic shadow_freq_sel,
  input wire logic osc_req,
  input wire logic supply_check_req,
  input wire logic osc_cal_req,
  input wire logic fast_osc_freq_8m,
  input wire logic osc_on,
  input wire logic osc_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // One wait state, then a single ready pulse
  property p_wait; psel && $rose(penable) |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready held");
  property p_err;
    pready && paddr != 8'h00 && (pwrite || paddr != 8'h04) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("pslverr missing");
  property p_errd; pready && pslverr |-> prdata == 32'h0; endproperty
  a_errd: assert property (p_errd) else $error("error read not zero");
  property p_freq;
    !flow_mode |=> fast_osc_freq_8m == $past(shadow_freq_sel);
  endproperty
  a_freq: assert property (p_freq) else $error("shadow select ignored");
  property p_sup; supply_check_req |-> $past(meas_trig); endproperty
  a_sup: assert property (p_sup) else $error("supply req no trigger");
  property p_cal; osc_cal_req |-> $past(meas_trig); endproperty
  a_cal: assert property (p_cal) else $error("cal req no trigger");
  property p_on; osc_req |=> osc_on; endproperty
  a_on: assert property (p_on) else $error("osc not started");
  property p_rdon; osc_ready |-> osc_on; endproperty
  a_rdon: assert property (p_rdon) else $error("ready while off");
endmodule

bind fcpc_core fcpc_core_properties u_chk (.*);

// file: tb/fcpc_core_tb_top.sv
// Testbench for the fast clock and power configuration block
`timescale 1ns/1ps
module fcpc_core_tb_top
  import fcpc_pkg::*;
;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, meas_trig = '0, flow_mode = '1;
  logic shadow_freq_sel = '0, osc_req = '0, gph_req = '0;
  logic hbr_en = '0, hbr_activity = '0, supply_check_req, osc_cal_req;
  logic fast_osc_freq_8m, osc_on, osc_ready;
  logic [33:0] e;
  logic [33:0] exp_q [$];
  int fail_count = 0, compares = 0, n_sup = 0, n_cal = 0, t;
  // Short counts: settle is code plus four cycles, cal divisor is code
  fcpc_core #(
    .SETTLE_CYC('{24'h4,24'h5,24'h6,24'h7,24'h8,24'h9,24'ha,24'hb}),
    .FAST_BAUD_OSC_TIMEOUT_CYC('{24'ha,24'h14,24'h1e,24'h28,24'h3c,24'h50,24'h64,24'h78}),
    .CAL_DIV('{7'h0,7'h1,7'h2,7'h3,7'h4,7'h5,7'h6,7'h7})
  ) DUT (.*);
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
    compares++;
    if (s !== x)
    begin
      fail_count++;
      $display("Error %s exp %h got %h", nm, x, s);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Note layout: check data, error, data
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d, logic [33:0] x);
    int k;
    exp_q.push_back(x);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (pready !== 1'b1)
    begin
      fail_count++;
      $display("Error pready exp 1 got %b", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this step
    @(posedge pclk);
  endtask
  // Back-to-back triggers, the tightest spacing allowed
  task automatic trig(int n);
    repeat (n)
    begin
      meas_trig <= 1'b1;
      @(posedge pclk);
    end
    meas_trig <= 1'b0;
    cyc(2);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    n_sup += supply_check_req;
    n_cal += osc_cal_req;
    if (pready === 1'b1 && exp_q.size() == 0)
    begin
      fail_count++;
      $display("Error pready exp 0 got 1");
    end
    else if (pready === 1'b1)
    begin
      e = exp_q.pop_front();
      chk("pslverr", e[32], pslverr);
      if (e[33])
        chk("prdata", e[31:0], prdata);
    end
  end
  initial
  begin
    cyc(20000);
    fail_count++;
    stop_test();
  end
  initial
  begin
    r = $urandom(32'h0bc4);
    cyc(10);
    presetn <= 1'b1;
    apb(8'h00, 0, 0, {2'h2, FCPC_CFG_RST});
    r = $urandom;
    apb(8'h00, 1, r | 32'h3, 34'h0);
    apb(8'h04, 0, 0, {2'h2, 28'h0, 1'b1, r[8], 2'h0});
    apb(8'h00, 0, 0, {2'h2, 16'h0, r[15:2], 2'h0});
    apb(8'h00, 1, r & 32'hfffc, 34'h0);
    apb(8'h04, 0, 0, {2'h2, 28'h0, 1'b0, r[8], 2'h0});
    apb(8'h08, 0, 0, {2'h3, 32'h0});
    apb(8'h04, 1, 32'hf, {2'h1, 32'h0});
    for (int c = 1; c < 8; c++)
    begin
      apb(8'h00, 1, 32'h0138, 34'h0);
      apb(8'h00, 1, {16'h0, 3'(c), 1'b0, 3'(c), 9'h138}, 34'h0);
      n_sup = 0;
      n_cal = 0;
      trig(3 * FCPC_SUPPLY_DIV[c] - 1);
      chk("supply", 2, n_sup);
      chk("calrate", (3 * FCPC_SUPPLY_DIV[c] - 1) / c, n_cal);
    end
    apb(8'h00, 1, 32'h0338, 34'h0);
    n_cal = 0;
    trig(3);
    chk("cal", 3, n_cal);
    apb(8'h00, 1, 32'h0138, 34'h0);
    n_sup = 0;
    n_cal = 0;
    trig(5);
    chk("off", 0, n_sup + n_cal);
    for (int i = 0; i < 8; i++)
    begin
      flow_mode <= i[0];
      shadow_freq_sel <= i[1];
      apb(8'h00, 1, {23'h0, i[2], 8'h38}, 34'h0);
      cyc(2);
      chk("freq", i[0] ? i[2] : i[1], fast_osc_freq_8m);
    end
    gph_req <= 1'b1;
    cyc(3);
    chk("gph0", 0, osc_on);
    apb(8'h00, 1, 32'h1138, 34'h0);
    cyc(3);
    chk("gph1", 1, osc_on);
    gph_req <= 1'b0;
    for (int c = 0; c < 8; c += 7)
    begin
      apb(8'h00, 1, {16'h0, 11'h009, 3'(c), 2'h0}, 34'h0);
      osc_req <= 1'b1;
      t = 0;
      @(posedge pclk);
      while (osc_ready !== 1'b1 && t < 100)
      begin
        @(posedge pclk);
        t++;
      end
      chk("settle", c + 5, t);
      osc_req <= 1'b0;
      cyc(3);
    end
    apb(8'h00, 1, 32'h0140, 34'h0);
    hbr_en <= 1'b1;
    hbr_activity <= 1'b1;
    @(posedge pclk);
    hbr_activity <= 1'b0;
    cyc(25);
    chk("hold", 1, osc_on);
    cyc(11);
    chk("expire", 0, osc_on);
    hbr_en <= 1'b0;
    cyc(2);
    stop_test();
  end
endmodule
